// ### src/arr_cfg.svh
// Notes on behaviour
// - Hold-off clear: flag latches until condition ended and its register read.
// - Hold-off set: flag follows the qualified condition, read or not.
// - Source bits 3..0 pick external, thermal, temp high, temp low alarms.
// - Selected alarms reach the alarm pin only while the pin is enabled.
// - Span code 0xx auto, 100 -10..0, 101 -5..0, 110 0..10, 111 0..5 V.
// - First span register: group B in 6..4, group A in 2..0, manual overrides auto.
// - Second span register: group D in 6..4, group C in 2..0, same decode.
// - 12-bit straight binary result; low byte 7..0, high nibble 11..8.
// - Results read-only at 0x20..0x49, zero after reset until written.
// - Temperature low byte at 0x4a holds reading bits 7..0, two's complement.
// - Reserved bits reset to zero and read back zero.
// - Source and span registers reset to 0x00.
// - Flag sets only after N consecutive out-of-range conversions.
// - Temperature high byte at 0x4b holds bits 11..8, upper nibble zero.
`ifndef ARR_CFG_SVH
`define ARR_CFG_SVH

`define ARR_IDX_W 8
`define ARR_IDX_AOS 8'h1d
`define ARR_IDX_SPAN_AB 8'h1e
`define ARR_IDX_SPAN_CD 8'h1f
`define ARR_IDX_RES_FIRST 8'h20
`define ARR_IDX_RES_LAST 8'h49
`define ARR_IDX_TEMP_LO 8'h4a
`define ARR_IDX_TEMP_HI 8'h4b
`define ARR_IDX_FLAGS 8'h74
`define ARR_IDX_PIN_EN 8'h75
`define ARR_IDX_IRQ_STAT 8'h76
`define ARR_IDX_IRQ_MASK 8'h77

`define ARR_RST_BYTE 8'h00
`define ARR_AOS_MASK 8'h1f
`define ARR_SPAN_MASK 8'h77
`define ARR_FLAGS_MASK 8'h0f
`define ARR_PIN_EN_MASK 8'h01
`define ARR_IRQ_MASK 8'h3f
`define ARR_HOLD_OFF_BIT 4
`define ARR_SPAN_HI_LSB 4
`define ARR_SPAN_MANUAL_BIT 2
`define ARR_ALARMS 4
`define ARR_GROUPS 4
`define ARR_CHANNELS 21
`define ARR_IRQ_W 6
`define ARR_IRQ_RES_BIT 4
`define ARR_IRQ_TEMP_BIT 5

`endif

// ### src/arr_pkg.sv
package arr_pkg;

  // Effective output span of one group
  typedef enum logic [1:0] {
    ARR_SPAN_NEG10 = 2'b00,
    ARR_SPAN_NEG5 = 2'b01,
    ARR_SPAN_POS10 = 2'b10,
    ARR_SPAN_POS5 = 2'b11
  } arr_span_e;

  // Conversion result delivered by the converter
  typedef struct packed {
    logic valid;
    logic [4:0] chan;
    logic [11:0] data;
  } arr_result_s;

  // Temperature reading delivered by the sensor
  typedef struct packed {
    logic valid;
    logic [11:0] data;
  } arr_temp_s;

endpackage

// ### src/arr_regs.sv
`include "arr_cfg.svh"

module arr_regs #(
  parameter int ALARM_CONSEC = 4,
  parameter int CHANNELS = `ARR_CHANNELS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter side
  input wire logic conv_done,
  input wire logic [`ARR_ALARMS-1:0] alarm_raw,
  input wire arr_pkg::arr_result_s result_in,
  input wire arr_pkg::arr_temp_s temp_in,
  input wire logic [2*`ARR_GROUPS-1:0] auto_span,
  // Outputs to the device
  output logic alarm_output_pin,
  output logic [2*`ARR_GROUPS-1:0] group_output_span,
  output logic [`ARR_ALARMS-1:0] alarm_flags,
  output logic irq
);

  localparam int CW = $clog2(ALARM_CONSEC + 1);
  localparam logic [CW-1:0] CONSEC_N = CW'(ALARM_CONSEC);

  // Register state
  logic [7:0] aos_r;
  logic [7:0] span_ab_r;
  logic [7:0] span_cd_r;
  logic pin_en_r;
  logic [`ARR_IRQ_W-1:0] irq_stat_r;
  logic [`ARR_IRQ_W-1:0] irq_mask_r;
  logic [11:0] res_r [CHANNELS];
  logic [11:0] temp_r;
  logic [`ARR_ALARMS-1:0] flag_r;
  logic [`ARR_ALARMS-1:0] read_seen_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic pin_r;
  logic [2*`ARR_GROUPS-1:0] span_out_r;
  logic irq_r;

  // Bus decode
  logic [`ARR_IDX_W-1:0] idx;
  logic setup;
  logic done;
  logic wr_done;
  logic rd_done;
  logic lane0;
  logic [7:0] wbyte;
  logic [31:0] rd_nxt;
  logic err_nxt;
  logic rd_flags;
  logic rd_irq;
  logic [`ARR_IRQ_W-1:0] irq_ev;
  logic [`ARR_ALARMS-1:0] cond_q;
  logic [`ARR_ALARMS-1:0] flag_rise;
  logic [7:0] res_off;
  logic [4:0] res_chan;

  assign idx = paddr[`ARR_IDX_W+1:2];
  assign setup = psel & ~penable;
  assign done = psel & penable & pready_r;
  assign wr_done = done & pwrite & ~pslverr_r;
  assign rd_done = done & ~pwrite & ~pslverr_r;
  assign lane0 = pstrb[0];
  assign wbyte = pwdata[7:0];
  assign res_off = idx - `ARR_IDX_RES_FIRST;
  assign res_chan = res_off[5:1];

  // Read side effects fire only at the completing edge
  assign rd_flags = rd_done & (idx == `ARR_IDX_FLAGS);
  assign rd_irq = rd_done & (idx == `ARR_IDX_IRQ_STAT);

  // Read data mux, sampled in the setup cycle
  always_comb begin
    rd_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    if (idx >= `ARR_IDX_RES_FIRST && idx <= `ARR_IDX_RES_LAST) begin
      if (res_off[0]) begin
        rd_nxt[3:0] = res_r[res_chan][11:8];
      end else begin
        rd_nxt[7:0] = res_r[res_chan][7:0];
      end
    end else begin
      unique case (idx)
        `ARR_IDX_AOS: rd_nxt[7:0] = aos_r;
        `ARR_IDX_SPAN_AB: rd_nxt[7:0] = span_ab_r;
        `ARR_IDX_SPAN_CD: rd_nxt[7:0] = span_cd_r;
        `ARR_IDX_TEMP_LO: rd_nxt[7:0] = temp_r[7:0];
        `ARR_IDX_TEMP_HI: rd_nxt[3:0] = temp_r[11:8];
        `ARR_IDX_FLAGS: rd_nxt[`ARR_ALARMS-1:0] = flag_r;
        `ARR_IDX_PIN_EN: rd_nxt[0] = pin_en_r;
        `ARR_IDX_IRQ_STAT: rd_nxt[`ARR_IRQ_W-1:0] = irq_stat_r;
        `ARR_IDX_IRQ_MASK: rd_nxt[`ARR_IRQ_W-1:0] = irq_mask_r;
        default: err_nxt = 1'b1;
      endcase
    end
  end

  // No wait state; read data registered in the setup cycle comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup;
    end
  end

  // Refusal stands only with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else if (setup) begin
      pslverr_r <= err_nxt;
    end else if (done) begin
      pslverr_r <= 1'b0;
    end
  end

  // Read data zero outside the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
    end else if (done) begin
      prdata_r <= 32'h0000_0000;
    end
  end

  // Alarm source select and hold-off bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aos_r <= `ARR_RST_BYTE;
    end else if (wr_done && lane0 && idx == `ARR_IDX_AOS) begin
      aos_r <= wbyte & `ARR_AOS_MASK;
    end
  end

  // Span register, groups A and B
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      span_ab_r <= `ARR_RST_BYTE;
    end else if (wr_done && lane0 && idx == `ARR_IDX_SPAN_AB) begin
      span_ab_r <= wbyte & `ARR_SPAN_MASK;
    end
  end

  // Span register, groups C and D
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      span_cd_r <= `ARR_RST_BYTE;
    end else if (wr_done && lane0 && idx == `ARR_IDX_SPAN_CD) begin
      span_cd_r <= wbyte & `ARR_SPAN_MASK;
    end
  end

  // Alarm pin enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_en_r <= 1'b0;
    end else if (wr_done && lane0 && idx == `ARR_IDX_PIN_EN) begin
      pin_en_r <= wbyte[0];
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= '0;
    end else if (wr_done && lane0 && idx == `ARR_IDX_IRQ_MASK) begin
      irq_mask_r <= wbyte[`ARR_IRQ_W-1:0];
    end
  end

  // Result storage; the bus has no write path here
  // bus writes ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < CHANNELS; c++) begin
        res_r[c] <= 12'h000;
      end
    end else if (result_in.valid && 32'(result_in.chan) < CHANNELS) begin
      res_r[result_in.chan] <= result_in.data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_r <= 12'h000;
    end else if (temp_in.valid) begin
      temp_r <= temp_in.data;
    end
  end

  // Per-alarm qualification and flag
  for (genvar i = 0; i < `ARR_ALARMS; i++) begin : g_alarm
    logic [CW-1:0] cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_r <= '0;
      end else if (conv_done) begin
        if (!alarm_raw[i]) begin
          cnt_r <= '0;
        end else if (cnt_r != CONSEC_N) begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end

    assign cond_q[i] = (cnt_r == CONSEC_N);
    assign flag_rise[i] = cond_q[i] & ~flag_r[i];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        flag_r[i] <= 1'b0;
      end else if (aos_r[`ARR_HOLD_OFF_BIT]) begin
        flag_r[i] <= cond_q[i];
      end else if (cond_q[i]) begin
        flag_r[i] <= 1'b1;
      end else if (read_seen_r[i] || rd_flags) begin
        flag_r[i] <= 1'b0;
      end
    end

    // Read while still active is remembered, not acted on
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        read_seen_r[i] <= 1'b0;
      end else if (!flag_r[i]) begin
        read_seen_r[i] <= 1'b0;
      end else if (rd_flags) begin
        read_seen_r[i] <= 1'b1;
      end
    end
  end

  // Interrupt events: new alarm, new result, new temperature
  always_comb begin
    irq_ev = '0;
    irq_ev[`ARR_ALARMS-1:0] = flag_rise;
    irq_ev[`ARR_IRQ_RES_BIT] = result_in.valid;
    irq_ev[`ARR_IRQ_TEMP_BIT] = temp_in.valid;
  end

  // Set wins over the read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (rd_irq ? '0 : irq_stat_r) | irq_ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Alarm pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_r <= 1'b0;
    end else begin
      // bit order ext, thermal, high, low
      pin_r <= pin_en_r & |(flag_r & aos_r[`ARR_ALARMS-1:0]);
    end
  end

  // Effective span per group
  for (genvar g = 0; g < `ARR_GROUPS; g++) begin : g_span
    logic [2:0] code;
    if (g < 2) begin : g_ab
      assign code = span_ab_r[(g*`ARR_SPAN_HI_LSB)+:3];
    end else begin : g_cd
      assign code = span_cd_r[((g-2)*`ARR_SPAN_HI_LSB)+:3];
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        span_out_r[2*g+:2] <= arr_pkg::ARR_SPAN_NEG10;
      end else begin
        unique case (code)
          3'b100: span_out_r[2*g+:2] <= arr_pkg::ARR_SPAN_NEG10;
          3'b101: span_out_r[2*g+:2] <= arr_pkg::ARR_SPAN_NEG5;
          3'b110: span_out_r[2*g+:2] <= arr_pkg::ARR_SPAN_POS10;
          3'b111: span_out_r[2*g+:2] <= arr_pkg::ARR_SPAN_POS5;
          3'b000, 3'b001, 3'b010, 3'b011: span_out_r[2*g+:2] <= auto_span[2*g+:2];
        endcase
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign alarm_output_pin = pin_r;
  assign group_output_span = span_out_r;
  assign alarm_flags = flag_r;
  assign irq = irq_r;

endmodule

// ### testbench/arr_host.sv
module arr_host (
  // Clock
  input wire logic pclk,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
  end
  // Wait edge first, so back-to-back calls never drive twice per step
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
    output logic [7:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ### testbench/arr_regs_monitor.sv
module arr_regs_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Device
  input wire logic conv_done,
  input wire logic [3:0] alarm_raw,
  input wire logic [7:0] auto_span,
  input wire logic alarm_output_pin,
  input wire logic [7:0] group_output_span,
  input wire logic [3:0] alarm_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one pulse");
  a_idle_zero: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("answer outside access");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unmapped_err: assert property (pready && paddr[9:2] inside {[8'h00:8'h1c],
    [8'h4c:8'h73], [8'h78:8'hff]} |-> pslverr && prdata == 32'h0)
    else $error("unmapped not refused");
  a_high_nibble: assert property (pready && !pwrite && paddr[2] &&
    paddr[9:2] inside {[8'h21:8'h4b]} |-> prdata[7:4] == 4'h0)
    else $error("high byte upper nibble set");
  a_flag_rise: assert property ($rose(alarm_flags[0]) |-> $past(alarm_raw[0], 2) &&
    ($past(conv_done) || $past(conv_done, 2) || $past(conv_done, 3)))
    else $error("flag rose without conversion");
  a_flag_fall: assert property ($fell(alarm_flags[0]) |-> !$past(alarm_raw[0], 2))
    else $error("flag fell during condition");
  a_pin_cause: assert property (alarm_output_pin |-> $past(|alarm_flags))
    else $error("pin high without flag");
  a_span_cause: assert property ($changed(group_output_span) |->
    $past(pready && pwrite, 2) || $changed(auto_span) || $past(auto_span) != $past(auto_span, 2))
    else $error("span changed without cause");
endmodule

bind arr_regs arr_regs_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .conv_done(conv_done), .alarm_raw(alarm_raw), .auto_span(auto_span),
  .alarm_output_pin(alarm_output_pin), .group_output_span(group_output_span),
  .alarm_flags(alarm_flags));

// ### testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, conv_done, pin, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, raw, flags;
  logic [7:0] aspan, span, rd;
  logic [4:0] ch;
  logic [11:0] d;
  arr_pkg::arr_result_s res;
  arr_pkg::arr_temp_s tmp;
  int err_total, n_compared, seed, cyc;
  logic [7:0] ids [11] = '{8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h49, 8'h4a, 8'h4b, 8'h74, 8'h75,
    8'h76, 8'h77};
  arr_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  arr_regs #(.ALARM_CONSEC(2)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_done(conv_done),
    .alarm_raw(raw), .result_in(res), .temp_in(tmp), .auto_span(aspan),
    .alarm_output_pin(pin), .group_output_span(span), .alarm_flags(flags), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    u_host.xfer(1'b1, idx, v, rd, err);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    u_host.xfer(1'b0, idx, 8'h00, rd, err);
    check(rd, exp);
  endtask
  task automatic conv(input logic [3:0] r);
    raw <= r;
    @(posedge pclk);
    conv_done <= 1'b1;
    @(posedge pclk);
    conv_done <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  function automatic logic [1:0] xs(input int c, input logic [1:0] a);
    xs = c[2] ? c[1:0] : a;
  endfunction
  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Ceiling well above the several hundred cycles the run needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    {presetn, conv_done, raw, res, tmp, aspan, cyc, seed} = '0;
    seed = 36;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ids[i]) rdc(ids[i], 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(8'h1d + 8'(i), 8'hff);
      rdc(8'h1d + 8'(i), i == 0 ? 8'h1f : 8'h77);
    end
    wr(8'h1d, 8'h00);
    for (int c = 0; c < 8; c++) begin
      aspan <= 8'($random(seed));
      wr(8'h1e, {1'b0, 3'(7 - c), 1'b0, 3'(c)});
      wr(8'h1f, {1'b0, 3'(c), 1'b0, 3'(7 - c)});
      repeat (3) @(posedge pclk);
      check(span, {xs(c, aspan[7:6]), xs(7 - c, aspan[5:4]),
        xs(7 - c, aspan[3:2]), xs(c, aspan[1:0])});
    end
    repeat (4) begin
      ch = 5'({$random(seed)} % 21);
      d = 12'($random(seed));
      res <= {1'b1, ch, d};
      tmp <= {1'b1, d};
      @(posedge pclk);
      res <= '0;
      tmp <= '0;
      for (int w = 0; w < 2; w++) begin
        rdc(8'h20 + {ch, 1'b0}, d[7:0]);
        rdc(8'h21 + {ch, 1'b0}, {4'h0, d[11:8]});
        rdc(8'h4a, d[7:0]);
        rdc(8'h4b, {4'h0, d[11:8]});
        wr(8'h20 + {ch, 1'b0}, 8'hff);
        wr(8'h4b, 8'hff);
      end
    end
    u_host.xfer(1'b0, 8'h50, 8'h00, rd, err);
    check({err, rd[6:0]}, 8'h80);
    wr(8'h77, 8'h01);
    conv(4'h1);
    check({irq, 3'h0, flags}, 8'h00);
    conv(4'h1);
    check({irq, 3'h0, flags}, 8'h81);
    conv(4'h0);
    check({4'h0, flags}, 8'h01);
    rdc(8'h74, 8'h01);
    repeat (2) @(posedge pclk);
    check({4'h0, flags}, 8'h00);
    rdc(8'h76, 8'h31);
    repeat (2) @(posedge pclk);
    check({7'h0, irq}, 8'h00);
    conv(4'h1);
    conv(4'h1);
    rdc(8'h74, 8'h01);
    check({4'h0, flags}, 8'h01);
    conv(4'h0);
    check({4'h0, flags}, 8'h00);
    conv(4'h1);
    conv(4'h0);
    conv(4'h1);
    check({4'h0, flags}, 8'h00);
    conv(4'h0);
    wr(8'h1d, 8'h10);
    wr(8'h75, 8'h01);
    for (int k = 0; k < 4; k++) begin
      conv(4'(1 << k));
      conv(4'(1 << k));
      for (int s = 0; s < 4; s++) begin
        wr(8'h1d, 8'h10 | 8'(1 << s));
        repeat (3) @(posedge pclk);
        check({7'h0, pin}, {7'h0, s == k});
      end
      conv(4'h0);
      check({4'h0, flags}, 8'h00);
    end
    conv(4'h8);
    conv(4'h8);
    wr(8'h75, 8'h00);
    repeat (3) @(posedge pclk);
    check({pin, 3'h0, flags}, 8'h08);
    wrap_up();
  end
endmodule
